/* File: rtl/tco_top.sv */
// Channel 4 output-compare core with its register file.
`default_nettype none
`include "tco_defines.svh"
module tco_top (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire tco_pkg::tco_cmp_t    counter_value,
  input  wire logic                 count_down,
  input  wire logic                 update_event,
  input  wire logic                 trigger_in,
  output var  logic                 ch4_reference_signal,
  output var  logic                 ch4_output_pin
);
  import tco_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mode_reg;
    tco_cmp_t    cmp_buffer;
    tco_cmp_t    cmp_active;
    logic        polarity;
    logic        one_pulse;
    logic        ref_level;
    logic        pin_level;
    logic        match_seen;
    logic        prev_cmp;
    tco_mode_t   prev_mode;
  } tco_core_st_t;

  tco_core_st_t s;
  tco_core_st_t next_s;

  tco_if bus ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  tco_apb u_apb (
    .clk_sys (clk_sys),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.apb)
  );

  tco_trig u_trig (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .trigger_in (trigger_in),
    .trg        (bus.trig)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // PWM level for a comparison outcome; mode 2 is the inverse of 1
  function automatic logic pwm_level(input logic mode2,
                                     input logic down,
                                     input logic below,
                                     input logic not_above);
    logic lvl;
    lvl = down ? not_above : below;
    return mode2 ? ~lvl : lvl;
  endfunction : pwm_level

  // Read decode: returns the word and whether the address is mapped
  function automatic logic [32:0] reg_read(input logic [7:0] a,
                                           input tco_core_st_t st);
    logic [31:0] w;
    logic        h;
    w = `TCO_WORD_ZERO;
    h = 1'b1;
    case (a)
      `TCO_OFF_MODE:    w[15:0] = st.mode_reg;
      `TCO_OFF_COMPARE: w[`TCO_CMP_W-1:0] = st.cmp_buffer;
      `TCO_OFF_OUTCTL:  w[`TCO_POL_BIT] = st.polarity;
      `TCO_OFF_CTRL2:   w[`TCO_OPM_BIT] = st.one_pulse;
      `TCO_OFF_STATUS: begin
        w[`TCO_ST_REF_BIT]   = st.ref_level;
        w[`TCO_ST_PIN_BIT]   = st.pin_level;
        w[`TCO_ST_MATCH_BIT] = st.match_seen;
        w[`TCO_ST_ACT_LO +: `TCO_CMP_W] = st.cmp_active;
      end
      default: h = 1'b0;
    endcase
    return {h, w};
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Decoded fields and comparison outcomes
  // ----------------------------------------------------------------
  tco_mode_t mode;
  logic      is_output;
  logic      buf_en;
  logic      fast_en;
  logic      is_pwm;
  logic      is_pwm2;
  logic      match;
  logic      below;
  logic      not_above;
  logic      cmp_now;
  logic      raw_cmp;
  logic      match_lvl;
  logic      wr_mode;
  logic      wr_cmp;
  logic      wr_outctl;
  logic      wr_ctrl2;
  logic      wr_status;

  // Direction field gates every compare field of the channel
  assign mode      = tco_mode_t'(s.mode_reg[`TCO_MODE_HI:`TCO_MODE_LO]);
  assign is_output = s.mode_reg[`TCO_DIR_HI:`TCO_DIR_LO]
                     == `TCO_DIR_OUTPUT;
  assign buf_en    = is_output & s.mode_reg[`TCO_BE_BIT];
  assign fast_en   = is_output & s.mode_reg[`TCO_FE_BIT];
  assign is_pwm    = (mode == TCO_PWM1) || (mode == TCO_PWM2);
  assign is_pwm2   = mode == TCO_PWM2;

  // Compare against the active copy, never the buffer
  assign match     = counter_value == s.cmp_active;
  assign below     = counter_value < s.cmp_active;
  assign not_above = counter_value <= s.cmp_active;
  assign cmp_now   = pwm_level(is_pwm2, count_down, below, not_above);
  // Raw outcome, the same in every mode, so a forced level survives
  // a move into PWM while the comparison itself stays put
  assign raw_cmp   = pwm_level(1'b0, count_down, below, not_above);
  // Level that a match itself would produce in the current direction
  assign match_lvl = pwm_level(is_pwm2, count_down, 1'b0, 1'b1);

  // Register write strobes
  assign wr_mode   = bus.wr_en && bus.addr == `TCO_OFF_MODE;
  assign wr_cmp    = bus.wr_en && bus.addr == `TCO_OFF_COMPARE;
  assign wr_outctl = bus.wr_en && bus.addr == `TCO_OFF_OUTCTL;
  assign wr_ctrl2  = bus.wr_en && bus.addr == `TCO_OFF_CTRL2;
  assign wr_status = bus.wr_en && bus.addr == `TCO_OFF_STATUS;

  // Read path goes back to the bus slave
  assign {bus.hit, bus.rdata} = reg_read(bus.addr, s);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Configuration registers
    if (wr_mode) begin
      next_s.mode_reg = bus.wdata[15:0];
    end
    if (wr_outctl) begin
      next_s.polarity = bus.wdata[`TCO_POL_BIT];
    end
    // One-pulse select is stored for software; buffering in PWM
    // outside one-pulse use is left to software to keep
    if (wr_ctrl2) begin
      next_s.one_pulse = bus.wdata[`TCO_OPM_BIT];
    end

    // Compare value: the buffer always takes the write; the active
    // copy takes it at once only when buffering is off. A write and
    // an update in one cycle load the old buffer, the write lands
    // in the buffer for the next update.
    if (wr_cmp) begin
      next_s.cmp_buffer = bus.wdata[`TCO_CMP_W-1:0];
    end
    if (wr_cmp && !buf_en) begin
      next_s.cmp_active = bus.wdata[`TCO_CMP_W-1:0];
    end else if (update_event && buf_en) begin
      next_s.cmp_active = s.cmp_buffer;
    end

    // Sticky match flag: write one to clear, a new match wins
    if (wr_status && bus.wdata[`TCO_ST_MATCH_BIT]) begin
      next_s.match_seen = 1'b0;
    end
    if (is_output && match) begin
      next_s.match_seen = 1'b1;
    end

    // Reference level; held as is while the channel is an input
    if (is_output) begin
      unique case (mode)
        TCO_FROZEN: begin
          next_s.ref_level = s.ref_level;
        end
        TCO_SET_MATCH: begin
          if (match) begin
            next_s.ref_level = 1'b1;
          end
        end
        TCO_CLR_MATCH: begin
          if (match) begin
            next_s.ref_level = 1'b0;
          end
        end
        TCO_TOGGLE: begin
          if (match) begin
            next_s.ref_level = ~s.ref_level;
          end
        end
        TCO_FORCE_LOW: begin
          next_s.ref_level = 1'b0;
        end
        TCO_FORCE_HIGH: begin
          next_s.ref_level = 1'b1;
        end
        TCO_PWM1, TCO_PWM2: begin
          // Level moves only on a new outcome, on leaving frozen or input direction, or on a PWM 1/2 swap,
          // so a forced fast-path level survives until then
          // Swapping PWM 1 and PWM 2 inverts the level, so it applies
          if (raw_cmp != s.prev_cmp || s.prev_mode == TCO_FROZEN ||
              s.prev_mode == (is_pwm2 ? TCO_PWM1 : TCO_PWM2)) begin
            next_s.ref_level = cmp_now;
          end
          // Trigger edge acts as a match regardless of comparison
          if (fast_en && bus.trig_edge) begin
            next_s.ref_level = match_lvl;
          end
        end
      endcase
    end
    // With fast off the trigger has no path here: the counter it
    // starts outside reaches the output through the compare only

    // History for the PWM change detection
    next_s.prev_cmp  = raw_cmp;
    next_s.prev_mode = is_output ? mode : TCO_FROZEN;

    // Pin level derived from the reference through the polarity
    next_s.pin_level = next_s.ref_level ^ next_s.polarity;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s            <= '0;
      s.mode_reg   <= `TCO_MODE_RST;
      s.cmp_buffer <= `TCO_CMP_RST;
      s.cmp_active <= `TCO_CMP_RST;
      s.prev_mode  <= TCO_FROZEN;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign ch4_reference_signal = s.ref_level;
  assign ch4_output_pin       = s.pin_level;
endmodule : tco_top
`default_nettype wire

/* File: rtl/tco_defines.svh */
// Constants for the channel 4 output-compare block.
`ifndef TCO_DEFINES_SVH
`define TCO_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCO_OFF_MODE      8'h00
`define TCO_OFF_COMPARE   8'h04
`define TCO_OFF_OUTCTL    8'h08
`define TCO_OFF_CTRL2     8'h0C
`define TCO_OFF_STATUS    8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TCO_MODE_HI       14
`define TCO_MODE_LO       12
`define TCO_BE_BIT        11
`define TCO_FE_BIT        10
`define TCO_DIR_HI        9
`define TCO_DIR_LO        8
`define TCO_DIR_OUTPUT    2'h0
`define TCO_POL_BIT       0
`define TCO_OPM_BIT       3
`define TCO_ST_REF_BIT    0
`define TCO_ST_PIN_BIT    1
`define TCO_ST_MATCH_BIT  2
`define TCO_ST_ACT_LO     16
`define TCO_MODE_RST      16'h0000
`define TCO_CMP_RST       16'h0000
`define TCO_WORD_ZERO     32'h0000_0000
`define TCO_CMP_W         16

`endif

/* File: rtl/tco_pkg.sv */
// Types shared by the channel 4 output-compare modules.
`default_nettype none
`include "tco_defines.svh"
package tco_pkg;

  // Output-compare mode codes
  typedef enum logic [2:0] {
    TCO_FROZEN     = 3'b000,
    TCO_SET_MATCH  = 3'b001,
    TCO_CLR_MATCH  = 3'b010,
    TCO_TOGGLE     = 3'b011,
    TCO_FORCE_LOW  = 3'b100,
    TCO_FORCE_HIGH = 3'b101,
    TCO_PWM1       = 3'b110,
    TCO_PWM2       = 3'b111
  } tco_mode_t;

  typedef logic [`TCO_CMP_W-1:0] tco_cmp_t;

endpackage : tco_pkg
`default_nettype wire

/* File: rtl/tco_if.sv */
// Carrier between the bus slave, trigger front end and core.
`default_nettype none
interface tco_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic [31:0] rdata;
  logic        hit;
  logic        trig_edge;

  modport apb  (output addr, output wdata, output wr_en,
                input rdata, input hit);
  modport trig (output trig_edge);
  modport core (input addr, input wdata, input wr_en,
                output rdata, output hit, input trig_edge);
endinterface : tco_if
`default_nettype wire

/* File: rtl/tco_apb.sv */
// APB slave front end: no wait state, registered answer.
`default_nettype none
`include "tco_defines.svh"
module tco_apb (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  tco_if.apb               bus
);
  import tco_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tco_apb_st_t;

  tco_apb_st_t s;
  tco_apb_st_t next_s;

  // Address and data pass straight to the core decode
  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;
  // Write lands only at the edge where pready is sampled high
  assign bus.wr_en = psel & penable & pwrite & s.pready & bus.hit;

  // Answer is prepared in the setup cycle, shown in the access cycle
  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && !penable) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = ~bus.hit;
      next_s.prdata  = bus.hit ? bus.rdata : `TCO_WORD_ZERO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
endmodule : tco_apb
`default_nettype wire

/* File: rtl/tco_trig.sv */
// Trigger pin synchroniser and rising-edge detector.
`default_nettype none
module tco_trig (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic trigger_in,
  tco_if.trig       trg
);
  import tco_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tco_trig_st_t;

  tco_trig_st_t s;
  tco_trig_st_t next_s;

  // Only the second stage and its delayed copy feed the edge test
  always_comb begin
    next_s      = s;
    next_s.meta = trigger_in;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Combinational edge keeps the fast path within three edges
  assign trg.trig_edge = s.sync & ~s.last;
endmodule : tco_trig
`default_nettype wire

/* File: test/tco_chk.sv */
// Concurrent checks on the ports of the channel 4 output-compare block.
`default_nettype none
module tco_chk import tco_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       pready,
  input wire tco_cmp_t   counter_value,
  input wire logic       count_down,
  input wire logic       update_event,
  input wire logic       trigger_in,
  input wire logic       ch4_reference_signal,
  input wire logic       ch4_output_pin
);
  // ------------------------------------------------------------
  // Register shadow, fed by completed bus writes and, for the active copy, by update_event
  // ------------------------------------------------------------
  logic [15:0] m, bf, act;
  logic        pol, p_oc, p_out;
  logic [2:0]  p_md;
  wire wr = psel && penable && pready && pwrite;
  wire out = m[9:8] == 2'h0;
  wire [2:0] md = m[14:12];
  wire lt = count_down ? counter_value <= act : counter_value < act;
  wire oc = lt ^ md[0];

  // Same-cycle write and update loads the old buffer, as the core does
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      m <= 16'h0000;
      bf <= 16'h0000;
      act <= 16'h0000;
      pol <= 1'b0;
      p_oc <= 1'b0;
      p_out <= 1'b1;
      p_md <= 3'h0;
    end else begin
      if (wr && paddr == 8'h00) m <= pwdata[15:0];
      if (wr && paddr == 8'h04) bf <= pwdata[15:0];
      if (wr && paddr == 8'h08) pol <= pwdata[0];
      if (wr && paddr == 8'h04 && !(m[11] && out)) act <= pwdata[15:0];
      else if (update_event && m[11] && out) act <= bf;
      p_oc <= oc;
      p_out <= out;
      p_md <= md;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_dir_holds: assert property (!out |=> $stable(ch4_reference_signal))
    else $error("reference moved while channel is an input");
  a_pin_polarity: assert property (pol == $past(pol) |->
    ch4_output_pin == (ch4_reference_signal ^ pol))
    else $error("pin does not follow reference and polarity");
  a_frozen_holds: assert property (out && md == TCO_FROZEN |=>
    $stable(ch4_reference_signal)) else $error("frozen mode moved reference");
  a_set_match: assert property (out && md == TCO_SET_MATCH &&
    counter_value == act |=> ch4_reference_signal)
    else $error("match did not set reference");
  a_clear_match: assert property (out && md == TCO_CLR_MATCH &&
    counter_value == act |=> !ch4_reference_signal)
    else $error("match did not clear reference");
  a_toggle_match: assert property (out && md == TCO_TOGGLE &&
    counter_value == act |=> ch4_reference_signal != $past(ch4_reference_signal))
    else $error("match did not toggle reference");
  a_force_level: assert property (out && md[2:1] == 2'b10 |=>
    ch4_reference_signal == $past(md[0])) else $error("forced level wrong");
  a_pwm_level: assert property (out && md[2:1] == 2'b11 && !m[10] &&
    ((p_md[2:1] == 2'b11 && oc != p_oc) || p_md == TCO_FROZEN) |=>
    ch4_reference_signal == $past(oc)) else $error("pwm level wrong");
  a_pwm_hold: assert property (out && p_out && md[2:1] == 2'b11 &&
    md == p_md && !m[10] && oc == p_oc |=> $stable(ch4_reference_signal))
    else $error("pwm reference moved without outcome change");
  a_fast_force: assert property (out && m[10] && md[2:1] == 2'b11 &&
    $rose(trigger_in) |-> ##3 ch4_reference_signal == (md[0] ^ count_down))
    else $error("fast trigger did not force compare level");

  c_status_read: cover property (wr == 1'b0 && pready && paddr == 8'h10);
  c_toggle: cover property (out && md == TCO_TOGGLE && counter_value == act);
  c_fast: cover property (m[10] && $rose(trigger_in));
endmodule : tco_chk

bind tco_top tco_chk u_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .counter_value(counter_value), .count_down(count_down),
  .update_event(update_event), .trigger_in(trigger_in),
  .ch4_reference_signal(ch4_reference_signal),
  .ch4_output_pin(ch4_output_pin));
`default_nettype wire

/* File: test/timer_channel4_output_compare_tb.sv */
// Self-checking bench for the channel 4 output-compare block.
`default_nettype none
module timer_channel4_output_compare_tb import tco_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, d;
  logic        pready, pslverr, e, ref_o, pin_o;
  tco_cmp_t    counter_value = 16'h0000;
  logic        count_down = 1'b0, update_event = 1'b0, trigger_in = 1'b0;
  logic [2:0]  md_tbl [7] = '{3'h3, 3'h0, 3'h2, 3'h1, 3'h4, 3'h5, 3'h3};
  logic [6:0]  exp_v = 7'h2B;
  int          num_errors = 0, checks = 0;

  tco_top u_tco_top (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(counter_value), .count_down(count_down),
    .update_event(update_event), .trigger_in(trigger_in),
    .ch4_reference_signal(ref_o), .ch4_output_pin(pin_o));

  // ------------------------------------------------------------
  // Bus cycles, comparison and expectation helpers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step

  task automatic chk(input string nm, input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // Level of a pwm mode against compare 0100, up or down
  function automatic logic lvl(input logic m0, input tco_cmp_t c,
                               input logic dn);
    return (dn ? c <= 16'h0100 : c < 16'h0100) ^ m0;
  endfunction : lvl

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (8000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    d = $urandom(74);
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      // Counter and compare both rest at zero, so the match flag sets
      chk("reset word", r, {29'h0, a == 16, 2'b00});
      chk("slave error", {31'h0, e}, {31'h0, a == 20});
    end
    d = $urandom;
    apb(1'b1, 8'h0C, d);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("one pulse", r, d & 32'h0000_0008);
    apb(1'b1, 8'h00, d);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("mode word", r, d & 32'h0000_FFFF);
    counter_value <= 16'h0041;
    // Force low gives the toggle step below a known start level
    apb(1'b1, 8'h00, 32'h0000_4000);
    apb(1'b1, 8'h04, 32'h0000_0040);
    apb(1'b1, 8'h10, 32'h0000_0004);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("active cmp", r >> 16, 32'h0000_0040);
    chk("status word", r, 32'h0040_0000);
    // One-cycle match per non-PWM mode; frozen must keep the level
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 8'h00, {17'h0, md_tbl[k], 12'h000});
      counter_value <= 16'h0040;
      step(1);
      counter_value <= 16'h0041;
      step(3);
      chk("match ref", {31'h0, ref_o}, {31'h0, exp_v[k]});
      chk("match pin", {31'h0, pin_o}, {31'h0, exp_v[k]});
    end
    apb(1'b1, 8'h08, 32'h0000_0001);
    step(2);
    chk("pin inverted", {31'h0, pin_o}, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0800);
    apb(1'b1, 8'h04, 32'h0000_0100);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("held cmp", r >> 16, 32'h0000_0040);
    update_event <= 1'b1;
    step(1);
    update_event <= 1'b0;
    step(1);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("buffer read", r, 32'h0000_0100);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("loaded cmp", r >> 16, 32'h0000_0100);
    // Boundary counts first, then random counts and directions
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, 32'h0000_6800 + 32'(i) * 32'h0000_1000);
      for (int j = 0; j < 24; j++) begin
        counter_value <= j < 3 ? 16'h00FF + 16'(j) : 16'($urandom_range(511));
        count_down <= j < 3 ? 1'b0 : 1'($urandom);
        step(2);
        chk("pwm", {31'h0, ref_o},
            {31'h0, lvl(i[0], counter_value, count_down)});
      end
    end
    count_down <= 1'b0;
    counter_value <= 16'h0000;
    apb(1'b1, 8'h00, 32'h0000_5800);
    apb(1'b1, 8'h00, 32'h0000_7800);
    step(3);
    chk("pwm hold", {31'h0, ref_o}, 32'h0000_0001);
    counter_value <= 16'h0105;
    step(2);
    counter_value <= 16'h0000;
    step(2);
    chk("pwm release", {31'h0, ref_o}, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_6C00);
    step(2);
    trigger_in <= 1'b1;
    step(5);
    chk("fast forced", {31'h0, ref_o}, 32'h0000_0000);
    trigger_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_6800);
    step(2);
    chk("forced kept", {31'h0, ref_o}, 32'h0000_0000);
    counter_value <= 16'h0105;
    step(2);
    counter_value <= 16'h0000;
    step(2);
    trigger_in <= 1'b1;
    step(6);
    chk("slow trigger", {31'h0, ref_o}, 32'h0000_0001);
    trigger_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0C00);
    trigger_in <= 1'b1;
    step(6);
    chk("fast frozen", {31'h0, ref_o}, 32'h0000_0001);
    trigger_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_4100);
    step(3);
    chk("input dir", {31'h0, ref_o}, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_4000);
    step(3);
    chk("output dir", {31'h0, ref_o}, 32'h0000_0000);
    chk("pin polarity", {31'h0, pin_o}, 32'h0000_0001);
    conclude();
  end
endmodule : timer_channel4_output_compare_tb
`default_nettype wire
